// ---- hdl/pdlf_defines.vh ----
// Constants of the packet-path latency buffer of one transceiver port.
// Assumes a single 40 MHz clock; all latency figures are in ns.
`ifndef PDLF_DEFINES_VH
`define PDLF_DEFINES_VH

// ****************************************************************
// Clock and speed codes
// ****************************************************************
`define PDLF_CLK_NS 25
`define PDLF_SPD_10 2'h0
`define PDLF_SPD_100 2'h1
`define PDLF_SPD_1000 2'h2

// ****************************************************************
// Minimum latencies with field at 00
// ****************************************************************
`define PDLF_CU_SG_1000_NS 292
`define PDLF_CU_SG_100_NS 620
`define PDLF_CU_SG_10_NS 4817
`define PDLF_SG_CU_1000_NS 192
`define PDLF_SG_CU_100_NS 528
`define PDLF_SG_CU_10_NS 3822
`define PDLF_CU_QS_1000_NS 308
`define PDLF_CU_QS_100_NS 628
`define PDLF_CU_QS_10_NS 4825
`define PDLF_QS_CU_1000_NS 222
`define PDLF_QS_CU_100_NS 506
`define PDLF_QS_CU_10_NS 3827

// ****************************************************************
// Latency field steps
// ****************************************************************
`define PDLF_STEP_1000_NS 8
`define PDLF_STEP_100_NS 40
`define PDLF_STEP_10_NS 400

// ****************************************************************
// Buffer and entry layout
// ****************************************************************
`define PDLF_FIFO_DEPTH 32
`define PDLF_STAMP_W 16
`define PDLF_E_DATA_LSB 0
`define PDLF_E_EOP 8
`define PDLF_E_SOP 9
`define PDLF_E_STAMP_LSB 10
`define PDLF_RST_VAL 1'b0

`endif

// ---- hdl/pdlf_fifo.v ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset copy.
`timescale 1ns/1ps
module pdlf_fifo #(
	parameter WIDTH = 26,
	parameter DEPTH = 32,
	parameter AW = 5
)(
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	wire empty;
	wire full;
	wire push;
	wire pop;

	// ****************************************************************
	// Status and storage
	// ****************************************************************
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &
		(wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push = in_valid_i & ~full;
	assign pop = out_valid_o & out_ready_i;

	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	// Storage has no reset; only pointers define contents
	always @(posedge sys_clk_i)
	begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
	end
endmodule // pdlf_fifo

// ---- hdl/pdlf_top.v ----
// Latency-controlled packet path of one port, both directions.
// Channel 0 runs copper to serial, channel 1 serial to copper.
// Assumes line decoding and serial coding sit outside; inputs are
// synchronous to sys_clk_i and carry one byte per accepted word.
`timescale 1ns/1ps
`include "pdlf_defines.vh"
module pdlf_top #(
	parameter FIFO_DEPTH = `PDLF_FIFO_DEPTH,
	parameter FIFO_AW = 5
)(
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [1:0] speed_i,
	input wire quad_mode_i,
	input wire [1:0] lat_cu2ser_i,
	input wire [1:0] lat_ser2cu_i,
	input wire [3:0] cu_rx_pair_vld_i,
	input wire [7:0] cu_rx_data_i,
	input wire cu_rx_sop_i,
	input wire cu_rx_eop_i,
	input wire cu_rx_dribble_i,
	output wire cu_rx_ready_o,
	output wire ser_tx_valid_o,
	input wire ser_tx_ready_i,
	output wire [7:0] ser_tx_data_o,
	output wire ser_tx_sop_o,
	output wire ser_tx_eop_o,
	input wire ser_rx_valid_i,
	input wire [7:0] ser_rx_data_i,
	input wire ser_rx_sop_i,
	input wire ser_rx_eop_i,
	output wire ser_rx_ready_o,
	output wire cu_tx_valid_o,
	input wire cu_tx_ready_i,
	output wire [7:0] cu_tx_data_o,
	output wire cu_tx_sop_o,
	output wire cu_tx_eop_o
);
	localparam SW = `PDLF_STAMP_W;
	localparam EW = SW + 10;

	reg rst_meta_reg;
	reg rst_sync_reg;
	reg [SW-1:0] now_reg;
	wire rst_n;
	wire cu_in_ok;
	wire cu_in_drop;
	wire [1:0] in_vld;
	wire [1:0] in_keep;
	wire [1:0] in_rdy;
	wire [15:0] in_data;
	wire [1:0] in_sop;
	wire [1:0] in_eop;
	wire [1:0] out_rdy;
	wire [1:0] out_vld;
	wire [15:0] out_data;
	wire [1:0] out_sop;
	wire [1:0] out_eop;

	// ****************************************************************
	// Reset release and free-running cycle stamp
	// ****************************************************************
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= `PDLF_RST_VAL;
			rst_sync_reg <= `PDLF_RST_VAL;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	always @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			now_reg <= {SW{1'b0}};
		else
			now_reg <= now_reg + 1'b1;
	end

	// ****************************************************************
	// Latency target in ns per direction, interface, speed and field
	// ****************************************************************
	function [15:0] target_ns;
		input dir;
		input quad;
		input [1:0] spd;
		input [1:0] fld;
		reg [15:0] base;
		reg [15:0] step;
		reg [17:0] add;
		begin
			base = 16'h0000;
			step = 16'h0000;
			add = 18'h00000;
			case ({dir, quad, spd})
			{1'b0, 1'b0, `PDLF_SPD_1000}: base = 16'd`PDLF_CU_SG_1000_NS;
			{1'b0, 1'b0, `PDLF_SPD_100}: base = 16'd`PDLF_CU_SG_100_NS;
			{1'b0, 1'b0, `PDLF_SPD_10}: base = 16'd`PDLF_CU_SG_10_NS;
			{1'b1, 1'b0, `PDLF_SPD_1000}: base = 16'd`PDLF_SG_CU_1000_NS;
			{1'b1, 1'b0, `PDLF_SPD_100}: base = 16'd`PDLF_SG_CU_100_NS;
			{1'b1, 1'b0, `PDLF_SPD_10}: base = 16'd`PDLF_SG_CU_10_NS;
			{1'b0, 1'b1, `PDLF_SPD_1000}: base = 16'd`PDLF_CU_QS_1000_NS;
			{1'b0, 1'b1, `PDLF_SPD_100}: base = 16'd`PDLF_CU_QS_100_NS;
			{1'b0, 1'b1, `PDLF_SPD_10}: base = 16'd`PDLF_CU_QS_10_NS;
			{1'b1, 1'b1, `PDLF_SPD_1000}: base = 16'd`PDLF_QS_CU_1000_NS;
			{1'b1, 1'b1, `PDLF_SPD_100}: base = 16'd`PDLF_QS_CU_100_NS;
			{1'b1, 1'b1, `PDLF_SPD_10}: base = 16'd`PDLF_QS_CU_10_NS;
			default: base = 16'h0000;
			endcase
			case (spd)
			`PDLF_SPD_1000: step = 16'd`PDLF_STEP_1000_NS;
			`PDLF_SPD_100: step = 16'd`PDLF_STEP_100_NS;
			`PDLF_SPD_10: step = 16'd`PDLF_STEP_10_NS;
			default: step = 16'h0000;
			endcase
			// Field 00 is the minimum; each step adds one speed increment
			add = {16'h0000, fld} * {2'h0, step};
			target_ns = base + add[15:0];
		end
	endfunction

	// ****************************************************************
	// Input qualification
	// ****************************************************************
	// Gigabit words count from the last of the four deskewed pairs
	assign cu_in_ok = (speed_i == `PDLF_SPD_1000) ?
		(&cu_rx_pair_vld_i) : cu_rx_pair_vld_i[0];
	// At 10M, dribble nibbles past frame alignment are consumed, never stored
	assign cu_in_drop = (speed_i == `PDLF_SPD_10) & cu_rx_dribble_i;

	assign in_vld = {ser_rx_valid_i, cu_in_ok};
	assign in_keep = {1'b1, ~cu_in_drop};
	assign in_data = {ser_rx_data_i, cu_rx_data_i};
	assign in_sop = {ser_rx_sop_i, cu_rx_sop_i};
	assign in_eop = {ser_rx_eop_i, cu_rx_eop_i};
	assign out_rdy = {cu_tx_ready_i, ser_tx_ready_i};
	assign cu_rx_ready_o = in_rdy[0];
	assign ser_rx_ready_o = in_rdy[1];
	assign ser_tx_valid_o = out_vld[0];
	assign ser_tx_data_o = out_data[7:0];
	assign ser_tx_sop_o = out_sop[0];
	assign ser_tx_eop_o = out_eop[0];
	assign cu_tx_valid_o = out_vld[1];
	assign cu_tx_data_o = out_data[15:8];
	assign cu_tx_sop_o = out_sop[1];
	assign cu_tx_eop_o = out_eop[1];

	// ****************************************************************
	// Per-direction elastic buffer and timed release
	// ****************************************************************
	genvar d;
	generate
		for (d = 0; d < 2; d = d + 1)
		begin : g_dir
			wire [EW-1:0] wr_word;
			wire [EW-1:0] rd_word;
			wire fifo_rdy;
			wire fifo_vld;
			wire [SW-1:0] age;
			wire [20:0] age_ns;
			wire [15:0] tgt;
			wire [1:0] fld;
			wire due;
			wire pop;
			reg vld_reg;
			reg [7:0] data_reg;
			reg sop_reg;
			reg eop_reg;

			// Word stamped on arrival; stalls push release later
			assign wr_word = {now_reg, in_sop[d], in_eop[d],
				in_data[d*8 +: 8]};
			assign in_rdy[d] = fifo_rdy;

			pdlf_fifo #(
				.WIDTH(EW),
				.DEPTH(FIFO_DEPTH),
				.AW(FIFO_AW)
			) u_fifo (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n),
				.in_valid_i(in_vld[d] & in_keep[d]),
				.in_ready_o(fifo_rdy),
				.in_data_i(wr_word),
				.out_valid_o(fifo_vld),
				.out_ready_i(pop),
				.out_data_o(rd_word)
			);

			assign fld = (d == 0) ? lat_cu2ser_i : lat_ser2cu_i;
			assign tgt = target_ns((d == 1), quad_mode_i, speed_i, fld);
			assign age = now_reg - rd_word[`PDLF_E_STAMP_LSB +: SW];
			assign age_ns = {5'h00, age} * 21'd25;
			// Output register adds one cycle, so release one cycle early.
			// Each word carries its own stamp, so the end delimiter sees
			// the same delay as the start only with no rate offset.
			assign due = (age_ns + 21'd`PDLF_CLK_NS) >= {5'h00, tgt};
			assign pop = fifo_vld & due & (~vld_reg | out_rdy[d]);

			always @(posedge sys_clk_i or negedge rst_n)
			begin
				if (!rst_n)
				begin
					vld_reg <= 1'b0;
					data_reg <= 8'h00;
					sop_reg <= 1'b0;
					eop_reg <= 1'b0;
				end
				else if (pop)
				begin
					vld_reg <= 1'b1;
					data_reg <= rd_word[`PDLF_E_DATA_LSB +: 8];
					sop_reg <= rd_word[`PDLF_E_SOP];
					eop_reg <= rd_word[`PDLF_E_EOP];
				end
				else if (out_rdy[d])
					vld_reg <= 1'b0;
			end

			assign out_vld[d] = vld_reg;
			assign out_data[d*8 +: 8] = data_reg;
			assign out_sop[d] = sop_reg;
			assign out_eop[d] = eop_reg;
		end
	endgenerate
endmodule // pdlf_top

// ---- test/pdlf_asserts.sv ----
// Port checker of the latency buffer.
// Assumes binding to pdlf_top; sees its ports only.
`timescale 1ns/1ps
module pdlf_asserts(
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [1:0] speed_i,
	input wire quad_mode_i,
	input wire [1:0] lat_cu2ser_i,
	input wire [1:0] lat_ser2cu_i,
	input wire [3:0] cu_rx_pair_vld_i,
	input wire cu_rx_dribble_i,
	input wire cu_rx_ready_o,
	input wire ser_tx_valid_o,
	input wire ser_tx_ready_i,
	input wire [7:0] ser_tx_data_o,
	input wire ser_rx_valid_i,
	input wire ser_rx_ready_o,
	input wire cu_tx_valid_o,
	input wire cu_tx_ready_i,
	input wire [7:0] cu_tx_data_o
);
	wire cu_tk;
	wire sr_tk;
	wire [4:0] cu_cfg;
	wire [4:0] sr_cfg;
	reg [7:0] cq_reg;
	reg [7:0] sq_reg;
	assign cu_tk = cu_rx_ready_o & ~(speed_i == 2'h0 & cu_rx_dribble_i)
		& (speed_i == 2'h2 ? &cu_rx_pair_vld_i : cu_rx_pair_vld_i[0]);
	assign sr_tk = ser_rx_valid_i & ser_rx_ready_o;
	assign cu_cfg = {speed_i, quad_mode_i, lat_cu2ser_i};
	assign sr_cfg = {speed_i, quad_mode_i, lat_ser2cu_i};
	// Idle time since last take; latency is only exact with nothing queued
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cq_reg <= 8'h00;
			sq_reg <= 8'h00;
		end
		else
		begin
			cq_reg <= cu_tk ? 8'h00 : cq_reg + {7'h00, ~&cq_reg};
			sq_reg <= sr_tk ? 8'h00 : sq_reg + {7'h00, ~&sq_reg};
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_cu_sg_gig;
		cu_tk && cu_cfg == 5'h10 && &cq_reg && !ser_tx_valid_o
		|-> ##11 !ser_tx_valid_o ##1 ser_tx_valid_o;
	endproperty
	a_cu_sg_gig: assert property (p_cu_sg_gig) else $error("gig cu lat");
	property p_cu_sg_ten;
		cu_tk && cu_cfg == 5'h00 && &cq_reg && !ser_tx_valid_o
		|-> ##192 !ser_tx_valid_o ##1 ser_tx_valid_o;
	endproperty
	a_cu_sg_ten: assert property (p_cu_sg_ten) else $error("10M cu lat");
	property p_cu_qs_fld;
		cu_tk && cu_cfg == 5'h0f && &cq_reg && !ser_tx_valid_o
		|-> ##29 !ser_tx_valid_o ##1 ser_tx_valid_o;
	endproperty
	a_cu_qs_fld: assert property (p_cu_qs_fld) else $error("cu field lat");
	property p_sr_sg_gig;
		sr_tk && sr_cfg == 5'h10 && &sq_reg && !cu_tx_valid_o
		|-> ##7 !cu_tx_valid_o ##1 cu_tx_valid_o;
	endproperty
	a_sr_sg_gig: assert property (p_sr_sg_gig) else $error("gig ser lat");
	property p_sr_qs_fast;
		sr_tk && sr_cfg == 5'h0c && &sq_reg && !cu_tx_valid_o
		|-> ##20 !cu_tx_valid_o ##1 cu_tx_valid_o;
	endproperty
	a_sr_qs_fast: assert property (p_sr_qs_fast) else $error("ser lat");
	property p_ser_hold;
		ser_tx_valid_o && !ser_tx_ready_i |=> ser_tx_valid_o && $stable(ser_tx_data_o);
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("ser word lost");
	property p_cu_hold;
		cu_tx_valid_o && !cu_tx_ready_i |=> cu_tx_valid_o && $stable(cu_tx_data_o);
	endproperty
	a_cu_hold: assert property (p_cu_hold) else $error("cu word lost");
	property p_cu_full;
		$fell(cu_rx_ready_o) |-> $past(cu_tk);
	endproperty
	a_cu_full: assert property (p_cu_full) else $error("full without write");
endmodule // pdlf_asserts
bind pdlf_top pdlf_asserts i_pdlf_asserts (.*);

// ---- test/pdlf_mac_model.sv ----
// Serial-side port model: takes copper-to-serial words, may stall.
// Assumes hold_i and rnd_i change just after the clock edge.
`timescale 1ns/1ps
module pdlf_mac_model(
	input wire sys_clk_i,
	input wire hold_i,
	input wire rnd_i,
	input wire valid_i,
	input wire [9:0] word_i,
	output reg ready_o
);
	integer seed = 29127;
	reg [9:0] got_q[$];
	initial ready_o = 1'b1;
	// Random stalls stand in for a rate offset between the two sides
	always @(posedge sys_clk_i)
	begin
		if (valid_i && ready_o)
			got_q.push_back(word_i);
		#1 ready_o = !hold_i && !(rnd_i && $random(seed) % 2);
	end
endmodule // pdlf_mac_model

// ---- test/testbench.sv ----
// Bench of the latency buffer: latency table, order, stalls and fill.
// Assumes pdlf_top, its bound checker and the serial-side model.
`timescale 1ns/1ps
module testbench;
	reg sys_clk_i = 0, rst_n_i = 0, hold = 0, rnd = 0;
	reg [1:0] speed_i = 0, lat_cu2ser_i = 0, lat_ser2cu_i = 0, f;
	reg quad_mode_i = 0, cu_rx_sop_i = 0, cu_rx_eop_i = 0, cu_rx_dribble_i = 0;
	reg [3:0] cu_rx_pair_vld_i = 0;
	reg [7:0] cu_rx_data_i = 0, ser_rx_data_i = 0, bc, bs;
	reg ser_rx_valid_i = 0, ser_rx_sop_i = 0, ser_rx_eop_i = 0, cu_tx_ready_i = 1;
	wire ser_tx_ready_i, cu_rx_ready_o, ser_tx_valid_o, ser_tx_sop_o, ser_tx_eop_o;
	wire ser_rx_ready_o, cu_tx_valid_o, cu_tx_sop_o, cu_tx_eop_o;
	wire [7:0] ser_tx_data_o, cu_tx_data_o;
	integer seed = 29127, miscompares = 0, num_checks = 0, i, n, m;
	reg [9:0] cu_q[$];
	pdlf_top i_pdlf_top (.*);
	pdlf_mac_model i_pdlf_mac_model(.sys_clk_i(sys_clk_i), .hold_i(hold),
		.rnd_i(rnd), .valid_i(ser_tx_valid_o), .ready_o(ser_tx_ready_i),
		.word_i({ser_tx_sop_o, ser_tx_eop_o, ser_tx_data_o}));
	always #12.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		if (cu_tx_valid_o && cu_tx_ready_i)
			cu_q.push_back({cu_tx_sop_o, cu_tx_eop_o, cu_tx_data_o});
		#1 cu_tx_ready_i = !(rnd && $random(seed) % 2);
	end
	task check(input [31:0] seen, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	function integer lat(input d, input q, input [1:0] s, input [1:0] l);
		integer m;
		begin
			if (!d && !q) m = s == 0 ? 4817 : s == 1 ? 620 : 292;
			if (!d && q) m = s == 0 ? 4825 : s == 1 ? 628 : 308;
			if (d && !q) m = s == 0 ? 3822 : s == 1 ? 528 : 192;
			if (d && q) m = s == 0 ? 3827 : s == 1 ? 506 : 222;
			m = m + l * (s == 0 ? 400 : s == 1 ? 40 : 8);
			lat = (m + 24) / 25;
		end
	endfunction
	// Lone word: gig pairs skewed, 10M dribble first, else bit0 low first
	task one(input d, input [7:0] v);
	begin
		@(posedge sys_clk_i);
		#1;
		lat_cu2ser_i = f;
		lat_ser2cu_i = f;
		{cu_rx_sop_i, cu_rx_eop_i, ser_rx_sop_i, ser_rx_eop_i} = 4'hf;
		if (d)
			{ser_rx_valid_i, ser_rx_data_i} = {1'b1, v};
		else
		begin
			{cu_rx_data_i, cu_rx_dribble_i} = {~v, speed_i == 2'h0};
			cu_rx_pair_vld_i = speed_i == 2'h2 ? 4'h7 : speed_i == 2'h0 ? 4'h1 : 4'he;
			@(posedge sys_clk_i);
			#1;
			{cu_rx_data_i, cu_rx_dribble_i, cu_rx_pair_vld_i} = {v, 5'h0f};
		end
		@(posedge sys_clk_i);
		#1;
		{cu_rx_pair_vld_i, ser_rx_valid_i} = 5'h00;
		for (n = 1; !(d ? cu_tx_valid_o : ser_tx_valid_o) && n < 400; n = n + 1)
			@(posedge sys_clk_i) #1;
		check(n, lat(d, quad_mode_i, speed_i, f));
		check(d ? {cu_tx_sop_o, cu_tx_eop_o, cu_tx_data_o} : {ser_tx_sop_o, ser_tx_eop_o, ser_tx_data_o}, {2'h3, v});
		repeat (260) @(posedge sys_clk_i);
		#1;
	end
	endtask
	task automatic burst(input d, input [7:0] b);
		integer k;
		reg r;
	begin
		@(posedge sys_clk_i);
		#1;
		for (k = 0; k < 20; k = k + 1)
		begin
			if (d)
				{ser_rx_valid_i, ser_rx_sop_i, ser_rx_eop_i, ser_rx_data_i} = {1'b1, k == 0, k == 19, b + k[7:0]};
			else
				{cu_rx_pair_vld_i, cu_rx_sop_i, cu_rx_eop_i, cu_rx_data_i} = {4'hf, k == 0, k == 19, b + k[7:0]};
			do
			begin
				@(negedge sys_clk_i) r = d ? ser_rx_ready_o : cu_rx_ready_o;
				@(posedge sys_clk_i) #1;
			end
			while (!r);
		end
		// Release only this channel; the other burst may still be running
		if (d)
			ser_rx_valid_i = 1'b0;
		else
			cu_rx_pair_vld_i = 4'h0;
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		#(25 * 60000) miscompares = miscompares + 1;
		end_of_test;
	end
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		#1 rst_n_i = 1;
		// Long idle first so the checker's idle counter saturates
		repeat (260) @(posedge sys_clk_i);
		#1;
		for (i = 0; i < 36; i = i + 1)
		begin
			speed_i = i % 3;
			quad_mode_i = (i / 3) % 2;
			f = (i / 6) % 3 == 0 ? 2'h0 : (i / 6) % 3 == 1 ? 2'h3 : $random(seed);
			one(i / 18, $random(seed));
		end
		// Both ways at once with both far ends stalling at random
		{speed_i, rnd, bc, bs} = {3'h5, 16'($random(seed))};
		i_pdlf_mac_model.got_q.delete();
		cu_q.delete();
		fork
			burst(0, bc);
			burst(1, bs);
		join
		repeat (300) @(posedge sys_clk_i);
		check(i_pdlf_mac_model.got_q.size() + cu_q.size(), 40);
		for (i = 0; i < 20; i = i + 1)
		begin
			check(i_pdlf_mac_model.got_q[i], {i == 0, i == 19, bc + i[7:0]});
			check(cu_q[i], {i == 0, i == 19, bs + i[7:0]});
		end
		// At 10M nothing leaves before the buffers fill, so refusal is exact
		i_pdlf_mac_model.got_q.delete();
		cu_q.delete();
		#1 {speed_i, rnd, hold, n} = 36'h100000000;
		{cu_rx_pair_vld_i, cu_rx_sop_i, cu_rx_eop_i} = 6'h04;
		{ser_rx_valid_i, ser_rx_sop_i, ser_rx_eop_i, m} = 35'h400000000;
		repeat (40)
		begin
			{cu_rx_data_i, ser_rx_data_i} = {n[7:0], m[7:0]};
			@(negedge sys_clk_i)
			begin
				n = n + cu_rx_ready_o;
				m = m + ser_rx_ready_o;
			end
			@(posedge sys_clk_i) #1;
		end
		{cu_rx_pair_vld_i, ser_rx_valid_i} = 5'h00;
		check(n, 32);
		check(m, 32);
		hold = 0;
		repeat (300) @(posedge sys_clk_i);
		for (i = 0; i < 32; i = i + 1)
		begin
			check(i_pdlf_mac_model.got_q[i], i);
			check(cu_q[i], i);
		end
		end_of_test;
	end
endmodule // testbench
